// >>> hw/cbt_pkg.sv
// shared constants and types for the can bit timing and message buffer block
package cbt_pkg;

    // register indices; byte address on apb is four times the index
    localparam logic [6:0] IDX_MCR1       = 7'h01;
    localparam logic [6:0] IDX_BT0        = 7'h02;
    localparam logic [6:0] IDX_BT1        = 7'h03;
    localparam logic [6:0] IDX_STATUS     = 7'h09;
    localparam logic [6:0] IDX_TX_PENDING = 7'h0a;

    // buffer index digit in the upper bits of the register index
    localparam logic [2:0] BUF_RX         = 3'h4;
    localparam logic [2:0] BUF_TX_FIRST   = 3'h5;
    localparam logic [2:0] BUF_TX_LAST    = 3'h7;
    localparam int unsigned NUM_TX        = 3;
    localparam int unsigned NUM_BUF       = 4;
    localparam int unsigned BUF_BYTES     = 14;

    // byte positions inside a message buffer
    localparam logic [3:0] BYTE_ID1       = 4'h1;
    localparam logic [3:0] BYTE_LENGTH    = 4'hc;
    localparam logic [3:0] BYTE_PRIORITY  = 4'hd;

    // field positions
    localparam int unsigned ORIGIN_POS    = 0;
    localparam int unsigned JUMP_POS      = 6;
    localparam int unsigned BRP_POS       = 0;
    localparam int unsigned TRIPLE_POS    = 7;
    localparam int unsigned SEG2_POS      = 4;
    localparam int unsigned SEG1_POS      = 0;
    localparam int unsigned EXT_FLAG_POS  = 3;

    // reset values
    localparam logic [7:0] MCR1_RST       = 8'h00;
    localparam logic [7:0] BT0_RST        = 8'h00;
    localparam logic [7:0] BT1_RST        = 8'h00;
    localparam logic [2:0] TX_PENDING_RST = 3'h0;
    localparam logic       CAN_TX_RST     = 1'b1;

    // position inside the bit time, one-hot
    typedef enum logic [2:0] {
        BT_SYNC = 3'b001,
        BT_SEG1 = 3'b010,
        BT_SEG2 = 3'b100
    } cbt_state_t;

endpackage

// >>> hw/cbt_prescaler.sv
// time quantum prescaler on the selected controller clock source
`timescale 1ns/1ns
`default_nettype none
module cbt_prescaler
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       xtal_tick,
    input  wire logic       pll_tick,
    input  wire logic       src_sel,
    input  wire logic [5:0] brp,
    output logic            tq_tick
);
    import cbt_pkg::*;

    logic       sel_tick;
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic       tq_r;
    logic       tq_nxt;

    // count ticks of the chosen source, one quantum per brp+1 ticks
    always_comb
    begin
        sel_tick = src_sel ? pll_tick : xtal_tick; // [RULE_01]
        cnt_nxt  = cnt_r;
        tq_nxt   = 1'b0;
        if (sel_tick)
        begin
            if (cnt_r >= brp) // [RULE_04]
            begin
                cnt_nxt = 6'h00;
                tq_nxt  = 1'b1;
            end
            else
            begin
                cnt_nxt = cnt_r + 6'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= 6'h00;
            tq_r  <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            tq_r  <= tq_nxt;
        end
    end

    assign tq_tick = tq_r;

    // a quantum only follows a tick of the selected source
    chk_tq_source: assert property (@(posedge pclk) disable iff (!presetn)
        tq_tick |-> $past(sel_tick)) // [RULE_01]
        else $error("quantum without a tick of the selected source");

endmodule // cbt_prescaler
`default_nettype wire

// >>> hw/cbt_top.sv
// can bit timing generator with message buffer storage behind apb
// Function
// RULE_01 - one select bit picks crystal or pll
// RULE_02 - rates 10 kbps to 1 Mbps supported
// RULE_03 - software picks source within 0.4% tolerance
// RULE_04 - prescaler divides clock into time quanta
// RULE_05 - bit is sync, segment one, segment two
// RULE_06 - segment one programmable 4 to 16 quanta
// RULE_07 - segment two programmable 2 to 8 quanta
// RULE_08 - jump width programmable 1 to 4 quanta
// RULE_09 - bit rate is quantum rate over quanta
// RULE_10 - length fields hold quanta minus one
// RULE_11 - software keeps timing settings standard compliant
// RULE_12 - new transmit bit at bit start
// RULE_13 - receive sample at segment boundary, triple optional
// RULE_14 - block spans 128 bytes of register space
// RULE_15 - all buffers share 16 byte layout
// RULE_16 - index digit 4 receive, 5-7 transmit
// RULE_17 - priority byte transmit only, 14-15 unused
// RULE_18 - buffer contents undefined after reset
// RULE_19 - receive buffer read only, transmit read/write
// RULE_20 - extended flag selects identifier layout
// RULE_21 - lowest priority pending buffer wins, index ties
// RULE_22 - quantum counter tracks bit, resync by jump
`timescale 1ns/1ns
`default_nettype none
module cbt_top
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [8:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        xtal_tick,
    input  wire logic        pll_tick,
    input  wire logic        can_rx_pin,
    output logic             can_tx_pin,
    input  wire logic        tx_bit,
    input  wire logic        bus_idle,
    input  wire logic        rx_store_we,
    input  wire logic [3:0]  rx_store_byte,
    input  wire logic [7:0]  rx_store_data,
    output logic             rx_bit,
    output logic             rx_bit_valid,
    output logic             tx_point,
    output logic [1:0]       arb_winner,
    output logic             arb_valid,
    output logic             arb_ext_format
);
    import cbt_pkg::*;

    // buffer index digit of a register index
    function automatic logic is_rxbuf(input logic [6:0] i);
        return i[6:4] == BUF_RX;
    endfunction

    function automatic logic is_txbuf(input logic [6:0] i);
        return i[6:4] >= BUF_TX_FIRST && i[6:4] <= BUF_TX_LAST;
    endfunction

    // byte of a buffer that holds storage; 13 for transmit only
    function automatic logic byte_held(input logic [6:0] i);
        return is_txbuf(i) ? (i[3:0] <= BYTE_PRIORITY) : (i[3:0] <= BYTE_LENGTH);
    endfunction

    logic [6:0]  idx;
    logic        setup;
    logic        wr_acc;
    logic [7:0]  mcr1_r, mcr1_nxt;
    logic [7:0]  bt0_r, bt0_nxt;
    logic [7:0]  bt1_r, bt1_nxt;
    logic [2:0]  txpend_r, txpend_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        err_r, err_nxt;
    logic [7:0]  mem_r   [0:NUM_BUF-1][0:BUF_BYTES-1];
    logic [7:0]  mem_nxt [0:NUM_BUF-1][0:BUF_BYTES-1];
    logic        rx_meta_r, rx_sync_r, rx_prev_r;
    logic        rx_fall;
    logic        tq_tick;
    cbt_state_t  st_r, st_nxt;
    logic [5:0]  cnt_r, cnt_nxt;
    logic [2:0]  ext_r, ext_nxt;
    logic [2:0]  shr_r, shr_nxt;
    logic        done_r, done_nxt;
    logic [1:0]  hist_r, hist_nxt;
    logic        rxb_r, rxb_nxt;
    logic        rxv_r, rxv_nxt;
    logic        tx_r, tx_nxt;
    logic        txpt_r, txpt_nxt;
    logic [1:0]  arb_r, arb_nxt;
    logic        arbv_r, arbv_nxt;
    logic        arbx_r, arbx_nxt;
    logic [2:0]  jump_q;
    logic [5:0]  seg1_end;
    logic [5:0]  seg2_end;
    logic [5:0]  left_q;
    logic [1:0]  sel_idx;
    logic        sel_valid;
    logic [23:0] prio_flat;

    assign idx    = paddr[8:2]; // [RULE_14]
    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pwrite && pstrb[0];
    assign pready = 1'b1;

    // control registers; config stays software owned
    always_comb
    begin
        mcr1_nxt   = mcr1_r;
        bt0_nxt    = bt0_r;
        bt1_nxt    = bt1_r;
        txpend_nxt = txpend_r;
        if (wr_acc)
        begin
            unique case (idx)
                IDX_MCR1:       mcr1_nxt   = {7'h00, pwdata[ORIGIN_POS]}; // [RULE_01]
                IDX_BT0:        bt0_nxt    = pwdata[7:0];
                IDX_BT1:        bt1_nxt    = pwdata[7:0];
                IDX_TX_PENDING: txpend_nxt = pwdata[2:0];
                default:        mcr1_nxt   = mcr1_r;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mcr1_r   <= MCR1_RST;
            bt0_r    <= BT0_RST;
            bt1_r    <= BT1_RST;
            txpend_r <= TX_PENDING_RST;
        end
        else
        begin
            mcr1_r   <= mcr1_nxt;
            bt0_r    <= bt0_nxt;
            bt1_r    <= bt1_nxt;
            txpend_r <= txpend_nxt;
        end
    end

    // read data taken in the setup cycle so prdata is a flop in access
    always_comb
    begin
        rdata_nxt = rdata_r;
        err_nxt   = err_r;
        if (setup)
        begin
            rdata_nxt = 32'h0000_0000;
            err_nxt   = 1'b0;
            if (is_rxbuf(idx) || is_txbuf(idx)) // [RULE_16]
            begin
                if (byte_held(idx)) // [RULE_17]
                    rdata_nxt[7:0] = mem_r[idx[5:4]][idx[3:0]];
            end
            else
            begin
                unique case (idx)
                    IDX_MCR1:       rdata_nxt[7:0] = mcr1_r;
                    IDX_BT0:        rdata_nxt[7:0] = bt0_r;
                    IDX_BT1:        rdata_nxt[7:0] = bt1_r;
                    IDX_TX_PENDING: rdata_nxt[2:0] = txpend_r;
                    IDX_STATUS:     rdata_nxt[7:0] = {1'b0, arbv_r, arb_r, rxb_r, st_r};
                    default:        err_nxt        = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata_r <= 32'h0000_0000;
            err_r   <= 1'b0;
        end
        else
        begin
            rdata_r <= rdata_nxt;
            err_r   <= err_nxt;
        end
    end

    assign prdata  = rdata_r;
    assign pslverr = psel && penable && err_r;

    // buffer storage; slot 0 is receive, slots 1..3 transmit
    always_comb
    begin
        mem_nxt = mem_r;
        if (rx_store_we && rx_store_byte <= BYTE_LENGTH) // [RULE_15]
            mem_nxt[0][rx_store_byte] = rx_store_data;
        if (wr_acc && is_txbuf(idx) && byte_held(idx)) // [RULE_19]
            mem_nxt[idx[5:4]][idx[3:0]] = pwdata[7:0];
    end

    // no reset here: contents are undefined until software or the receive port loads them
    always_ff @(posedge pclk)
    begin
        mem_r <= mem_nxt; // [RULE_18]
    end

    // pin synchroniser, then a copy for edge detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
            rx_prev_r <= 1'b1;
        end
        else
        begin
            rx_meta_r <= can_rx_pin;
            rx_sync_r <= rx_meta_r;
            rx_prev_r <= rx_sync_r;
        end
    end

    assign rx_fall = rx_prev_r && !rx_sync_r;

    cbt_prescaler u_presc
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .xtal_tick (xtal_tick),
        .pll_tick  (pll_tick),
        .src_sel   (mcr1_r[ORIGIN_POS]),
        .brp       (bt0_r[BRP_POS +: 6]), // [RULE_02]
        .tq_tick   (tq_tick)
    );

    always_comb
    begin
        for (int i = 0; i < NUM_TX; i++)
            prio_flat[i*8 +: 8] = mem_r[i+1][BYTE_PRIORITY];
    end

    cbt_tx_select u_sel
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .pending   (txpend_r),
        .prio      (prio_flat),
        .win_idx   (sel_idx),
        .win_valid (sel_valid)
    );

    // field plus one gives the length in quanta
    assign jump_q   = {1'b0, bt0_r[JUMP_POS +: 2]} + 3'h1; // [RULE_08] [RULE_10]
    assign seg1_end = {2'b00, bt1_r[SEG1_POS +: 4]} + 6'h01 + {3'b000, ext_r}; // [RULE_06] [RULE_10]
    assign seg2_end = {3'b000, bt1_r[SEG2_POS +: 3]} + 6'h01 - {3'b000, shr_r}; // [RULE_07] [RULE_10]
    assign left_q   = seg2_end - cnt_r;

    // bit timing: one resync per bit, hard sync while the bus is idle
    always_comb
    begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        ext_nxt  = ext_r;
        shr_nxt  = shr_r;
        done_nxt = done_r;
        hist_nxt = hist_r;
        rxb_nxt  = rxb_r;
        rxv_nxt  = 1'b0;
        txpt_nxt = 1'b0;
        tx_nxt   = tx_r;
        arb_nxt  = arb_r;
        arbv_nxt = arbv_r;
        arbx_nxt = arbx_r;
        if (rx_fall && bus_idle)
        begin
            // edge itself is the sync segment
            st_nxt   = BT_SEG1; // [RULE_22]
            cnt_nxt  = 6'h00;
            ext_nxt  = 3'h0;
            shr_nxt  = 3'h0;
            done_nxt = 1'b1;
        end
        else if (rx_fall && !done_r && st_r != BT_SYNC)
        begin
            done_nxt = 1'b1;
            if (st_r == BT_SEG1)
            begin
                // late edge lengthens segment one, capped by the jump width
                ext_nxt = ({3'b000, jump_q} < cnt_r + 6'h01) ? jump_q : cnt_r[2:0] + 3'h1; // [RULE_22]
                // the edge cycle still owns its quantum, else the stretch exceeds the jump width
                if (tq_tick)
                begin
                    hist_nxt = {hist_r[0], rx_sync_r};
                    cnt_nxt  = cnt_r + 6'h01; // [RULE_08]
                end
            end
            else if (left_q <= {3'b000, jump_q})
            begin
                // early edge close enough: start the next bit now
                st_nxt   = BT_SEG1;
                cnt_nxt  = 6'h00;
                ext_nxt  = 3'h0;
                shr_nxt  = 3'h0;
                txpt_nxt = 1'b1; // [RULE_12]
            end
            else
            begin
                shr_nxt = jump_q; // [RULE_22]
            end
        end
        else if (tq_tick)
        begin
            unique case (st_r)
                BT_SYNC:
                begin
                    st_nxt  = BT_SEG1; // [RULE_05]
                    cnt_nxt = 6'h00;
                end
                BT_SEG1:
                begin
                    hist_nxt = {hist_r[0], rx_sync_r};
                    if (cnt_r + 6'h01 >= seg1_end)
                    begin
                        // majority of three quanta when triple sampling
                        rxb_nxt = bt1_r[TRIPLE_POS] ? ((hist_r[1] & hist_r[0]) | (hist_r[1] & rx_sync_r) |
                                  (hist_r[0] & rx_sync_r)) : rx_sync_r; // [RULE_13]
                        rxv_nxt = 1'b1;
                        st_nxt  = BT_SEG2;
                        cnt_nxt = 6'h00;
                    end
                    else
                    begin
                        cnt_nxt = cnt_r + 6'h01;
                    end
                end
                BT_SEG2:
                begin
                    if (cnt_r + 6'h01 >= seg2_end) // [RULE_09]
                    begin
                        st_nxt   = BT_SYNC;
                        cnt_nxt  = 6'h00;
                        ext_nxt  = 3'h0;
                        shr_nxt  = 3'h0;
                        done_nxt = 1'b0;
                        txpt_nxt = 1'b1; // [RULE_12]
                    end
                    else
                    begin
                        cnt_nxt = cnt_r + 6'h01;
                    end
                end
            endcase
        end
        // transmit point: new bit out, selection latched before a frame
        if (txpt_nxt)
        begin
            tx_nxt = tx_bit; // [RULE_12]
            if (bus_idle)
            begin
                arb_nxt  = sel_idx; // [RULE_21]
                arbv_nxt = sel_valid;
                arbx_nxt = mem_r[sel_idx + 2'h1][BYTE_ID1][EXT_FLAG_POS]; // [RULE_20]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r   <= BT_SYNC;
            cnt_r  <= 6'h00;
            ext_r  <= 3'h0;
            shr_r  <= 3'h0;
            done_r <= 1'b0;
            hist_r <= 2'h3;
            rxb_r  <= 1'b1;
            rxv_r  <= 1'b0;
            tx_r   <= CAN_TX_RST;
            txpt_r <= 1'b0;
            arb_r  <= 2'h0;
            arbv_r <= 1'b0;
            arbx_r <= 1'b0;
        end
        else
        begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            ext_r  <= ext_nxt;
            shr_r  <= shr_nxt;
            done_r <= done_nxt;
            hist_r <= hist_nxt;
            rxb_r  <= rxb_nxt;
            rxv_r  <= rxv_nxt;
            tx_r   <= tx_nxt;
            txpt_r <= txpt_nxt;
            arb_r  <= arb_nxt;
            arbv_r <= arbv_nxt;
            arbx_r <= arbx_nxt;
        end
    end

    assign can_tx_pin     = tx_r;
    assign tx_point       = txpt_r;
    assign rx_bit         = rxb_r;
    assign rx_bit_valid   = rxv_r;
    assign arb_winner     = arb_r;
    assign arb_valid      = arbv_r;
    assign arb_ext_format = arbx_r;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // helper view of the receive buffer for the write guard
    logic [103:0] rx_flat;
    always_comb
    begin
        for (int i = 0; i < 13; i++)
            rx_flat[i*8 +: 8] = mem_r[0][i];
    end

    sequence seq_seg1_done;
        st_r == BT_SEG1 && tq_tick && !rx_fall && cnt_r + 6'h01 == seg1_end;
    endsequence

    sequence seq_seg2_done;
        st_r == BT_SEG2 && tq_tick && !rx_fall && cnt_r + 6'h01 == seg2_end;
    endsequence

    chk_sync_one_tq: assert property ((st_r == BT_SYNC && tq_tick) |=> st_r == BT_SEG1) // [RULE_05]
        else $error("sync segment did not last one quantum");
    chk_seg1_len: assert property (seq_seg1_done |=> (st_r == BT_SEG2 && rx_bit_valid)) // [RULE_06]
        else $error("segment one did not end at its programmed length");
    chk_seg2_len: assert property (seq_seg2_done |=> (st_r == BT_SYNC && tx_point)) // [RULE_07]
        else $error("segment two did not end at its programmed length");
    chk_jump_bound: assert property ((st_r == BT_SEG1 && rx_fall && !done_r && !bus_idle)
        |=> (ext_r != 3'h0 && ext_r <= $past(jump_q))) // [RULE_08]
        else $error("segment one extension outside the jump width");
    chk_tx_point: assert property (tx_point |-> can_tx_pin == $past(tx_bit)) // [RULE_12]
        else $error("transmit pin not loaded at the transmit point");
    chk_tx_hold: assert property (!tx_point |-> $stable(can_tx_pin)) // [RULE_12]
        else $error("transmit pin changed away from the transmit point");
    chk_single_sample: assert property ((rx_bit_valid && !bt1_r[TRIPLE_POS]) |-> rx_bit == $past(rx_sync_r)) // [RULE_13]
        else $error("received bit differs from the bus at the sample point");
    chk_rx_readonly: assert property ((wr_acc && is_rxbuf(idx) && !rx_store_we) |=> $stable(rx_flat)) // [RULE_19]
        else $error("bus write altered the receive buffer");
    chk_unused_zero: assert property ((setup && (is_rxbuf(idx) || is_txbuf(idx)) && !byte_held(idx))
        |=> prdata == 32'h0000_0000) // [RULE_17]
        else $error("unused buffer byte did not read as zero");

endmodule // cbt_top
`default_nettype wire

// >>> hw/cbt_tx_select.sv
// local priority selection among pending transmit buffers
`timescale 1ns/1ns
`default_nettype none
module cbt_tx_select
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [2:0]  pending,
    input  wire logic [23:0] prio,
    output logic [1:0]       win_idx,
    output logic             win_valid
);
    import cbt_pkg::*;

    logic [7:0] best;

    // strict less-than keeps the lower index on a tie
    always_comb
    begin
        win_idx   = 2'h0;
        win_valid = 1'b0;
        best      = 8'hff;
        for (int i = 0; i < NUM_TX; i++)
        begin
            if (pending[i] && (!win_valid || prio[i*8 +: 8] < best)) // [RULE_21]
            begin
                win_idx   = 2'(i);
                win_valid = 1'b1;
                best      = prio[i*8 +: 8];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_TX; g++)
        begin : g_chk
            chk_win_lowest: assert property (@(posedge pclk) disable iff (!presetn)
                (pending[g] && win_valid) |-> (pending[win_idx] && (prio[win_idx*8 +: 8] < prio[g*8 +: 8] ||
                (prio[win_idx*8 +: 8] == prio[g*8 +: 8] && win_idx <= 2'(g))))) // [RULE_21]
                else $error("transmit selection did not take the lowest priority");
        end
    endgenerate

endmodule // cbt_tx_select
`default_nettype wire

// >>> tb/cbt_can_node.sv
// far-side can node sharing the wired-and bus with the controller
`timescale 1ns/1ns
`default_nettype none
module cbt_can_node
(
    input  wire logic can_tx_pin,
    input  wire logic node_drive,
    output logic      can_rx_pin
);
    // dominant 0 wins; a released bus returns recessive through the pull-up
    assign can_rx_pin = can_tx_pin & ~node_drive;
endmodule // cbt_can_node
`default_nettype wire

// >>> tb/cbt_top_test.sv
// self-checking bench for the can bit timing and message buffer block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value at %0t: got %h want %h", $time, (g), (e)); end end
module cbt_top_test;
    import cbt_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [8:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0]  pstrb = 4'hf, rx_store_byte = '0;
    logic        pready, pslverr, err, xtal_tick = 0, pll_tick = 0, can_rx_pin, can_tx_pin;
    logic        tx_bit = 1, bus_idle = 1, rx_store_we = 0, rx_bit, rx_bit_valid, tx_point;
    logic        arb_valid, arb_ext_format, node_drive = 0;
    logic [7:0]  rx_store_data = '0, d, rxm [13], pr [3];
    logic [1:0]  arb_winner;
    logic [2:0]  ext;
    int          error_cnt = 0, check_count = 0, cyc = 0, n, p, s1, s2;

    cbt_top cbt_top_inst (.*);
    cbt_can_node cbt_can_node_inst (.can_tx_pin(can_tx_pin), .node_drive(node_drive), .can_rx_pin(can_rx_pin));

    always #25 pclk = ~pclk;

    // crystal ticks every cycle, pll every other, so a source swap doubles the bit
    always @(posedge pclk)
    begin
        xtal_tick <= 1;
        pll_tick <= ~pll_tick;
        cyc++;
        if (cyc == 40000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [6:0] idx, input logic [7:0] wd);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask

    task automatic wait_tp();
        do @(posedge pclk); while (tx_point !== 1'b1);
    endtask

    // lowest priority wins, lower index on a tie
    function automatic logic [1:0] pick();
        logic [1:0] w = 0;
        for (int i = 1; i < 3; i++)
            if (pr[i] < pr[w])
                w = 2'(i);
        return w;
    endfunction

    initial
    begin
        void'($urandom(32'h880f_e465));
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, IDX_MCR1, 0); `CHK(rd[7:0], MCR1_RST)
        apb(0, IDX_BT0, 0); `CHK(rd[7:0], BT0_RST)
        apb(0, IDX_BT1, 0); `CHK(rd[7:0], BT1_RST)
        apb(0, 7'h05, 0); `CHK(err, 1'b1)
        $display("test registers done");
        // receive buffer is filled by the hardware port only
        for (int i = 0; i < 13; i++)
        begin
            rxm[i] = 8'($urandom);
            rx_store_we <= 1;
            rx_store_byte <= i[3:0];
            rx_store_data <= rxm[i];
            @(posedge pclk);
        end
        rx_store_we <= 0;
        for (int b = 4; b < 8; b++)
            for (int i = 0; i < 16; i++)
            begin
                d = 8'($urandom);
                apb(1, {b[2:0], i[3:0]}, d);
                apb(0, {b[2:0], i[3:0]}, 0);
                `CHK(rd[7:0], b == 4 ? (i < 13 ? rxm[i] : 8'h00) : (i < 14 ? d : 8'h00))
            end
        $display("test buffers done");
        // first two rounds hit the shortest and longest segments
        for (int r = 0; r < 6; r++)
        begin
            p = (r == 0) ? 0 : $urandom_range(3);
            s1 = (r == 0) ? 3 : (r == 1) ? 15 : $urandom_range(15, 3);
            s2 = (r == 0) ? 1 : (r == 1) ? 7 : $urandom_range(7, 1);
            apb(1, IDX_MCR1, 8'(r % 2));
            apb(1, IDX_BT0, 8'(p));
            apb(1, IDX_BT1, 8'(s2 * 16 + s1));
            wait_tp();
            wait_tp();
            n = 0;
            do begin @(posedge pclk); n++; end while (tx_point !== 1'b1);
            `CHK(n, (r % 2 + 1) * (p + 1) * (s1 + s2 + 3))
        end
        $display("test bit timing done");
        // round zero forces a three-way tie
        for (int r = 0; r < 4; r++)
        begin
            for (int i = 0; i < 3; i++)
            begin
                pr[i] = (r == 0) ? 8'h40 : 8'($urandom_range(3));
                ext[i] = 1'($urandom_range(1));
                apb(1, {BUF_TX_FIRST + i[2:0], BYTE_PRIORITY}, pr[i]);
                apb(1, {BUF_TX_FIRST + i[2:0], BYTE_ID1}, {4'h0, ext[i], 3'h0});
            end
            apb(1, IDX_TX_PENDING, 8'h07);
            wait_tp();
            wait_tp();
            @(posedge pclk);
            `CHK({arb_valid, arb_winner, arb_ext_format}, {1'b1, pick(), ext[pick()]})
        end
        $display("test arbitration done");
        for (int v = 0; v < 2; v++)
        begin
            tx_bit <= v[0];
            node_drive <= !v[0];
            repeat (2) do @(posedge pclk); while (rx_bit_valid !== 1'b1);
            @(posedge pclk);
            `CHK(rx_bit, v[0])
            `CHK(can_tx_pin, v[0])
        end
        // late edge in segment one on a busy bus: bit grows by the two-quantum jump width
        apb(1, IDX_MCR1, 8'h00);
        apb(1, IDX_BT0, 8'h40);
        apb(1, IDX_BT1, 8'hbf);
        bus_idle <= 0;
        wait_tp();
        wait_tp();
        node_drive <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (tx_point !== 1'b1);
        `CHK(n, (15 + 3 + 3) + 2)
        do @(posedge pclk); while (rx_bit_valid !== 1'b1);
        `CHK(rx_bit, 1'b0)
        $display("test pins done");
        tally_and_finish();
    end
endmodule // cbt_top_test
`default_nettype wire
